/* rtl/sdlcms_pkg.sv */
// package: register map, field positions, reset values and enumerations for the sync transmit control block
package sdlcms_pkg;
  localparam logic [1:0] REG_MISC_CTRL = 2'h0;  // underrun-abort, loop, 6-bit sync, mark idle
  localparam logic [1:0] REG_MODE_CTRL = 2'h1;  // protocol mode, poll, break, enables, channel reset
  localparam logic [1:0] REG_STATUS    = 2'h2;  // status of the block
  localparam logic [1:0] REG_SYNC_PAT  = 2'h3;  // sync pattern, 16 bits

  localparam int BIT_SYNC6      = 0;
  localparam int BIT_LOOP       = 1;
  localparam int BIT_UND_ABORT  = 2;
  localparam int BIT_MARK_IDLE  = 3;

  localparam int FLD_MODE_LO    = 0;           // bits 1:0 protocol mode
  localparam int BIT_GO_POLL    = 2;
  localparam int BIT_BREAK      = 3;
  localparam int BIT_TX_EN      = 4;
  localparam int BIT_RX_EN      = 5;
  localparam int BIT_CHAN_RST   = 7;           // self-clearing channel reset

  localparam int BIT_ST_UNDERRUN = 0;          // transmit underrun / end of message
  localparam int BIT_ST_TXEMPTY  = 1;
  localparam int BIT_ST_ONLOOP   = 2;
  localparam int BIT_ST_SYNCED   = 3;
  localparam int BIT_ST_LOOPACT  = 4;

  localparam logic [7:0]  MISC_RESET = 8'h00;
  localparam logic [7:0]  MODE_RESET = 8'h00;
  localparam logic [15:0] SYNC_RESET = 16'h7E7E;
  localparam logic [7:0]  FLAG_CHAR  = 8'h7E;
  localparam logic [15:0] ABORT_FLAG = 16'h7EFF;   // eight ones then a flag, shifted lsb first
  localparam logic [4:0]  CLOSE_BITS = 5'h10;      // closing transmission is 16 bits
  localparam logic [2:0]  EOP_ONES   = 3'h7;       // end-of-poll: zero followed by seven ones

  typedef enum logic [1:0] {
    SDLCMS_ASYNC    = 2'h0,
    SDLCMS_MONOSYNC = 2'h1,
    SDLCMS_BISYNC   = 2'h2,
    SDLCMS_SDLC     = 2'h3
  } sdlcms_mode_type;
endpackage : sdlcms_pkg

/* rtl/sdlcms_ctrl.sv */
// transmit underrun closing, loop mode and short sync control of one serial channel
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps

module sdlcms_ctrl
  import sdlcms_pkg::*;
(
  input  wire logic        I_MCLK,       // 100 MHz clock
  input  wire logic        I_RST,        // asynchronous reset, active high
  input  wire logic [1:0]  I_ADDR,       // register address
  input  wire logic [7:0]  I_WDATA,      // write data
  input  wire logic        I_WR,         // write strobe
  input  wire logic        I_RD,         // read strobe
  output logic      [7:0]  O_RDATA,      // read data, cycle after strobe
  input  wire logic        I_BIT_TICK,   // one bit time of the serial clock, same domain
  input  wire logic        I_TX_DATA,    // serialiser data bit
  input  wire logic        I_TX_CRC,     // serialiser current CRC bit
  input  wire logic        I_TX_UNDERRUN,// pulse: transmit buffer ran dry mid frame
  input  wire logic        I_RXD,        // receive data pin
  output logic             O_TXD,        // transmit data pin
  output logic             O_RX_BIT,     // bit offered to the receiver
  output logic             O_TX_ENABLED, // transmitter allowed to send
  output logic             O_UNDERRUN_EVT,// pulse: closing transmission began
  output logic             O_TXEMPTY_EVT,// pulse: closing transmission ended
  output logic             O_SYNC6,      // 6-bit monosync characters in use
  output logic             O_RX_SYNC12   // 12-bit bisync receive match in use
);
  typedef enum logic [2:0] {S_DATA, S_CLOSE, S_IDLE_ONES} sdlcms_tx_type;

  logic [7:0]  misc_reg, misc_next, mode_reg, mode_next, rdata_reg, rdata_next;
  logic [15:0] sync_reg, sync_next;
  logic [2:0]  rxs_reg, rxs_next;
  logic        rxd;
  logic [15:0] rsh_reg, rsh_next;
  logic        on_loop_reg, on_loop_next, synced_reg, synced_next, loop_prev_reg, loop_prev_next;
  logic        und_st_reg, und_st_next, empty_st_reg, empty_st_next;
  logic [2:0]  ones_reg, ones_next;
  logic        zero_seen_reg, zero_seen_next;
  logic [3:0]  chr_cnt_reg, chr_cnt_next;
  sdlcms_tx_type tx_reg, tx_next;
  logic [4:0]  cls_cnt_reg, cls_cnt_next;
  logic        cls_abort_reg, cls_abort_next;
  logic        txd_next, rxbit_next, txen_next, uevt_next, eevt_next, sync6_next, s12_next;
  logic        txd_reg, rxbit_reg, txen_reg, uevt_reg, eevt_reg, sync6_reg, s12_reg;

  sdlcms_mode_type mode;
  logic loop_opt, sdlc, syncm, eop, sync_hit, abort_eff, boundary;
  logic [3:0] chr_len;
  logic [15:0] cmp_mask;

  always_comb begin
    mode      = sdlcms_mode_type'(mode_reg[FLD_MODE_LO +: 2]);
    sdlc      = (mode == SDLCMS_SDLC);
    syncm     = (mode == SDLCMS_MONOSYNC) || (mode == SDLCMS_BISYNC);
    loop_opt  = misc_reg[BIT_LOOP] && (mode != SDLCMS_ASYNC);
    abort_eff = misc_reg[BIT_UND_ABORT] && !loop_opt && !on_loop_reg;
    // short sync only in character modes
    sync6_next = (mode == SDLCMS_MONOSYNC) && misc_reg[BIT_SYNC6];
    s12_next   = (mode == SDLCMS_BISYNC) && misc_reg[BIT_SYNC6];
    unique case (mode)
      SDLCMS_MONOSYNC: begin
        chr_len  = sync6_next ? 4'h5 : 4'h7;
        cmp_mask = sync6_next ? 16'h003F : 16'h00FF;
      end
      SDLCMS_BISYNC: begin
        chr_len  = 4'h7;
        cmp_mask = s12_next ? 16'h0FFF : 16'hFFFF;
      end
      default: begin
        chr_len  = 4'h7;
        cmp_mask = 16'h00FF;
      end
    endcase
  end

  // registers and host port
  always_comb begin
    misc_next  = misc_reg;
    mode_next  = mode_reg;
    sync_next  = sync_reg;
    rdata_next = 8'h00;
    if (I_WR) begin
      unique case (I_ADDR)
        REG_MISC_CTRL: misc_next = {4'h0, I_WDATA[3:0]};
        REG_MODE_CTRL: mode_next = {1'b0, I_WDATA[6:0]};
        REG_SYNC_PAT:  sync_next = {sync_reg[7:0], I_WDATA};
        default: ;
      endcase
      if (I_ADDR == REG_MODE_CTRL && I_WDATA[BIT_CHAN_RST]) begin
        misc_next = MISC_RESET;
        mode_next = MODE_RESET;
      end
    end
    // break is dropped once sync loop has locked on a character boundary
    if (txen_next && syncm && loop_opt && !txen_reg)
      mode_next[BIT_BREAK] = 1'b0;
    if (I_RD) begin
      unique case (I_ADDR)
        REG_MISC_CTRL: rdata_next = misc_reg;
        REG_MODE_CTRL: rdata_next = mode_reg;
        REG_STATUS:    rdata_next = {3'h0, loop_opt, synced_reg, on_loop_reg, empty_st_reg, und_st_reg};
        REG_SYNC_PAT:  rdata_next = sync_reg[7:0];
      endcase
    end
  end

  // receive side: pin synchroniser, end-of-poll and sync hunt
  always_comb begin
    rxs_next = {rxs_reg[1:0], I_RXD};
    rxd      = rxs_reg[2];
    // loop in SDLC feeds transmit data straight back to the receiver until the station is on loop, then the pin
    rxbit_next = (sdlc && loop_opt && !on_loop_reg) ? txd_reg : rxd;
    rsh_next = rsh_reg;
    ones_next = ones_reg;
    zero_seen_next = zero_seen_reg;
    eop = 1'b0;
    if (I_BIT_TICK && (rxs_reg[1] == rxs_reg[2])) begin
      rsh_next = {rsh_reg[14:0], rxd};
      if (!rxd) begin
        zero_seen_next = 1'b1;
        ones_next = 3'h0;
      end else if (zero_seen_reg) begin
        ones_next = ones_reg + 3'h1;
        if (ones_reg == EOP_ONES - 3'h1) begin
          eop = 1'b1;
          zero_seen_next = 1'b0;
        end
      end
    end
    sync_hit = I_BIT_TICK && (({rsh_reg[14:0], rxd} & cmp_mask) == (sync_reg & cmp_mask));
    loop_prev_next = loop_opt;
    on_loop_next = on_loop_reg;
    if (sdlc && eop) begin
      if (loop_opt && mode_reg[BIT_GO_POLL])
        on_loop_next = 1'b1;
      else if (!loop_opt)
        on_loop_next = 1'b0;
    end
    if (!sdlc)
      on_loop_next = 1'b0;
    synced_next = synced_reg;
    chr_cnt_next = chr_cnt_reg;
    boundary = 1'b0;
    if (!(syncm && loop_opt) || (loop_opt && !loop_prev_reg)) begin
      synced_next = 1'b0;
      chr_cnt_next = 4'h0;
    end else if (I_BIT_TICK) begin
      if (!synced_reg && sync_hit && mode_reg[BIT_RX_EN]) begin
        synced_next = 1'b1;
        chr_cnt_next = 4'h0;
      end else if (synced_reg) begin
        boundary = (chr_cnt_reg == chr_len);
        chr_cnt_next = boundary ? 4'h0 : chr_cnt_reg + 4'h1;
      end
    end
    txen_next = mode_reg[BIT_TX_EN];
    if (syncm && loop_opt)
      txen_next = txen_reg || (synced_reg && boundary && mode_reg[BIT_TX_EN]);
  end

  // transmit closing sequence and idle line
  always_comb begin
    tx_next = tx_reg;
    cls_cnt_next = cls_cnt_reg;
    cls_abort_next = cls_abort_reg;
    uevt_next = 1'b0;
    eevt_next = 1'b0;
    und_st_next = und_st_reg;
    empty_st_next = empty_st_reg;
    if (I_RD && I_ADDR == REG_STATUS) begin
      und_st_next = 1'b0;
      empty_st_next = 1'b0;
    end
    unique case (tx_reg)
      S_DATA: begin
        if (sdlc && I_TX_UNDERRUN) begin
          tx_next = S_CLOSE;
          cls_cnt_next = 5'h0;
          cls_abort_next = abort_eff;
          uevt_next = 1'b1;
          und_st_next = 1'b1;
        end
      end
      S_CLOSE: begin
        if (I_BIT_TICK) begin
          cls_cnt_next = cls_cnt_reg + 5'h1;
          if (cls_cnt_reg == CLOSE_BITS - 5'h1) begin
            eevt_next = 1'b1;
            empty_st_next = 1'b1;
            tx_next = (cls_abort_reg && misc_reg[BIT_MARK_IDLE]) ? S_IDLE_ONES : S_DATA;
          end
        end
      end
      S_IDLE_ONES: begin
        if (!misc_reg[BIT_MARK_IDLE] || !sdlc)
          tx_next = S_DATA;
      end
      default: tx_next = S_DATA;
    endcase
    // sticky status: a new event wins over a read clear
    if (uevt_next) und_st_next = 1'b1;
    if (eevt_next) empty_st_next = 1'b1;
    if (tx_reg == S_CLOSE)
      txd_next = cls_abort_reg ? ABORT_FLAG[cls_cnt_reg[3:0]] : I_TX_CRC;
    else if (tx_reg == S_IDLE_ONES)
      txd_next = 1'b1;
    else if (syncm && loop_opt && !txen_reg)
      txd_next = !mode_reg[BIT_BREAK];
    else if (mode_reg[BIT_BREAK])
      txd_next = 1'b0;
    else if (sdlc && !mode_reg[BIT_TX_EN])
      txd_next = misc_reg[BIT_MARK_IDLE] ? 1'b1 : FLAG_CHAR[cls_cnt_reg[2:0]];
    else
      txd_next = I_TX_DATA;
    if (tx_reg != S_CLOSE && sdlc && !mode_reg[BIT_TX_EN] && I_BIT_TICK)
      cls_cnt_next = {2'h0, cls_cnt_reg[2:0] + 3'h1};
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      misc_reg <= MISC_RESET;
      mode_reg <= MODE_RESET;
      sync_reg <= SYNC_RESET;
      rdata_reg <= 8'h00;
      rxs_reg <= 3'h7;
      rsh_reg <= 16'h0000;
      ones_reg <= 3'h0;
      zero_seen_reg <= 1'b0;
      on_loop_reg <= 1'b0;
      loop_prev_reg <= 1'b0;
      synced_reg <= 1'b0;
      chr_cnt_reg <= 4'h0;
      tx_reg <= S_DATA;
      cls_cnt_reg <= 5'h0;
      cls_abort_reg <= 1'b0;
      und_st_reg <= 1'b0;
      empty_st_reg <= 1'b0;
      txd_reg <= 1'b1;
      rxbit_reg <= 1'b1;
      txen_reg <= 1'b0;
      uevt_reg <= 1'b0;
      eevt_reg <= 1'b0;
      sync6_reg <= 1'b0;
      s12_reg <= 1'b0;
    end else begin
      misc_reg <= misc_next;
      mode_reg <= mode_next;
      sync_reg <= sync_next;
      rdata_reg <= rdata_next;
      rxs_reg <= rxs_next;
      rsh_reg <= rsh_next;
      ones_reg <= ones_next;
      zero_seen_reg <= zero_seen_next;
      on_loop_reg <= on_loop_next;
      loop_prev_reg <= loop_prev_next;
      synced_reg <= synced_next;
      chr_cnt_reg <= chr_cnt_next;
      tx_reg <= tx_next;
      cls_cnt_reg <= cls_cnt_next;
      cls_abort_reg <= cls_abort_next;
      und_st_reg <= und_st_next;
      empty_st_reg <= empty_st_next;
      txd_reg <= txd_next;
      rxbit_reg <= rxbit_next;
      txen_reg <= txen_next;
      uevt_reg <= uevt_next;
      eevt_reg <= eevt_next;
      sync6_reg <= sync6_next;
      s12_reg <= s12_next;
    end
  end

  assign O_RDATA        = rdata_reg;
  assign O_TXD          = txd_reg;
  assign O_RX_BIT       = rxbit_reg;
  assign O_TX_ENABLED   = txen_reg;
  assign O_UNDERRUN_EVT = uevt_reg;
  assign O_TXEMPTY_EVT  = eevt_reg;
  assign O_SYNC6        = sync6_reg;
  assign O_RX_SYNC12    = s12_reg;
endmodule : sdlcms_ctrl

/* verification/sdlcms_ctrl_props.sv */
// concurrent checks on the ports of the sync transmit control block
`timescale 1ns/1ps
module sdlcms_ctrl_props (
  input  wire logic       I_MCLK,         // clock
  input  wire logic       I_RST,          // asynchronous reset
  input  wire logic       I_WR,           // write strobe
  input  wire logic       I_RD,           // read strobe
  input  wire logic [7:0] O_RDATA,        // read data
  input  wire logic       I_BIT_TICK,     // bit tick
  input  wire logic       I_TX_UNDERRUN,  // underrun pulse
  input  wire logic       O_UNDERRUN_EVT, // closing began
  input  wire logic       O_TXEMPTY_EVT,  // closing ended
  input  wire logic       O_SYNC6,        // 6-bit monosync
  input  wire logic       O_RX_SYNC12     // 12-bit bisync receive
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  AST_RDATA_IDLE: assert property (!$past(I_RD) |-> O_RDATA == 8'h00) else $error("read data outside answer cycle");
  AST_UND_CAUSE: assert property (O_UNDERRUN_EVT |-> $past(I_TX_UNDERRUN)) else $error("underrun event without cause");
  AST_UND_PULSE: assert property (O_UNDERRUN_EVT |=> !O_UNDERRUN_EVT) else $error("underrun event too long");
  AST_TXE_CAUSE: assert property (O_TXEMPTY_EVT |-> $past(I_BIT_TICK)) else $error("empty event off a bit tick");
  AST_TXE_PULSE: assert property (O_TXEMPTY_EVT |=> !O_TXEMPTY_EVT) else $error("empty event too long");
  // sixteen ticks can never fit in eight clocks
  AST_CLOSE_GAP: assert property (O_UNDERRUN_EVT |=> !O_TXEMPTY_EVT [*8]) else $error("closing ended early");
  AST_SYNC_EXCL: assert property (!(O_SYNC6 && O_RX_SYNC12)) else $error("both short sync modes");
  AST_SYNC_CAUSE: assert property ($changed(O_SYNC6) || $changed(O_RX_SYNC12) |-> $past(I_WR) || $past(I_WR, 2))
    else $error("sync length changed without a write");
  CV_UND: cover property (O_UNDERRUN_EVT);
  CV_TXE: cover property (O_TXEMPTY_EVT);
  CV_S6: cover property (O_SYNC6);
  CV_S12: cover property (O_RX_SYNC12);
endmodule : sdlcms_ctrl_props
bind sdlcms_ctrl sdlcms_ctrl_props sdlcms_ctrl_props_inst (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_WR(I_WR),
  .I_RD(I_RD), .O_RDATA(O_RDATA), .I_BIT_TICK(I_BIT_TICK), .I_TX_UNDERRUN(I_TX_UNDERRUN),
  .O_UNDERRUN_EVT(O_UNDERRUN_EVT), .O_TXEMPTY_EVT(O_TXEMPTY_EVT), .O_SYNC6(O_SYNC6), .O_RX_SYNC12(O_RX_SYNC12));

/* verification/sdlcms_station.sv */
// remote station model: sends end-of-poll sequences on the line
`timescale 1ns/1ps
module sdlcms_station (
  input  wire logic i_clk,  // clock
  input  wire logic i_tick, // bit tick
  input  wire logic i_send, // request one end-of-poll sequence
  output logic      o_rxd   // line toward the block
);
  logic [7:0] sh_reg = 8'hFF;
  logic       pend_reg = 1'b0;
  // load only on a tick so the leading zero lasts a full bit time
  always_ff @(posedge i_clk) begin
    if (i_send) pend_reg <= 1'b1;
    if (i_tick) begin
      if (pend_reg) begin
        sh_reg   <= 8'hFE;
        pend_reg <= 1'b0;
      end else sh_reg <= {1'b1, sh_reg[7:1]};
    end
  end
  // line rests marking between sequences
  assign o_rxd = sh_reg[0];
endmodule : sdlcms_station

/* verification/sdlc_sync_tx_misc_control_tb_top.sv */
// self-checking bench of the sync transmit control block
`timescale 1ns/1ps
module sdlc_sync_tx_misc_control_tb_top;
  import sdlcms_pkg::*;
  logic       I_MCLK = 0, I_RST = 1, I_WR = 0, I_RD = 0, I_BIT_TICK = 0, I_TX_CRC = 0, I_TX_UNDERRUN = 0;
  logic [1:0] I_ADDR = 2'h0, tcnt = 2'h0;
  logic [7:0] I_WDATA = 8'h00, O_RDATA;
  logic       I_RXD, O_TXD, O_RX_BIT, O_TX_ENABLED, O_UNDERRUN_EVT, O_TXEMPTY_EVT, O_SYNC6, O_RX_SYNC12, send = 0;
  logic       I_TX_DATA = 0;
  int         miscompares = 0, total_checks = 0, cycles = 0;
  sdlcms_ctrl sdlcms_ctrl_inst (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
    .I_RD(I_RD), .O_RDATA(O_RDATA), .I_BIT_TICK(I_BIT_TICK), .I_TX_DATA(I_TX_DATA), .I_TX_CRC(I_TX_CRC),
    .I_TX_UNDERRUN(I_TX_UNDERRUN), .I_RXD(I_RXD), .O_TXD(O_TXD), .O_RX_BIT(O_RX_BIT), .O_TX_ENABLED(O_TX_ENABLED),
    .O_UNDERRUN_EVT(O_UNDERRUN_EVT), .O_TXEMPTY_EVT(O_TXEMPTY_EVT), .O_SYNC6(O_SYNC6), .O_RX_SYNC12(O_RX_SYNC12));
  sdlcms_station sdlcms_station_inst (.i_clk(I_MCLK), .i_tick(I_BIT_TICK), .i_send(send), .o_rxd(I_RXD));
  initial begin
    forever #5 I_MCLK = ~I_MCLK;
  end
  // one bit every four clocks; the crc bit flips with each tick so a stuck path shows
  always @(posedge I_MCLK) begin
    tcnt <= tcnt + 2'h1;
    I_BIT_TICK <= (tcnt == 2'h3);
    if (tcnt == 2'h3) I_TX_CRC <= ~I_TX_CRC;
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge I_MCLK);
    I_ADDR <= a; I_WDATA <= d; I_WR <= 1'b1;
    @(posedge I_MCLK);
    I_WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] q);
    @(posedge I_MCLK);
    I_ADDR <= a; I_RD <= 1'b1;
    @(posedge I_MCLK);
    I_RD <= 1'b0;
    #1 q = O_RDATA;
  endtask : rd
  task automatic wait_tick();
    @(posedge I_MCLK iff I_BIT_TICK);
    #1;
  endtask : wait_tick
  task automatic settle();
    repeat (2) @(posedge I_MCLK);
    #1;
  endtask : settle
  task automatic t_reset();
    logic [7:0] q;
    chk({7'h00, O_TXD}, 8'h01);
    rd(REG_MISC_CTRL, q); chk(q, MISC_RESET);
    wr(REG_STATUS, 8'hFF); rd(REG_STATUS, q); chk(q, 8'h00);
    wr(REG_MISC_CTRL, 8'h0F); wr(REG_MODE_CTRL, 8'h01); settle();
    chk({7'h00, O_SYNC6}, 8'h01);
    wr(REG_MODE_CTRL, 8'h81); settle();
    rd(REG_MISC_CTRL, q); chk(q, 8'h00);
    chk({7'h00, O_SYNC6}, 8'h00);
  endtask : t_reset
  task automatic t_sync();
    for (int m = 0; m < 4; m++) begin
      wr(REG_MODE_CTRL, {6'h00, m[1:0]}); wr(REG_MISC_CTRL, 8'h01); settle();
      chk({7'h00, O_SYNC6}, {7'h00, m == 1});
      chk({7'h00, O_RX_SYNC12}, {7'h00, m == 2});
      wr(REG_MISC_CTRL, 8'h00); settle();
      chk({6'h00, O_SYNC6, O_RX_SYNC12}, 8'h00);
    end
  endtask : t_sync
  task automatic t_close(input logic [7:0] misc, input logic abort, input logic mark);
    wr(REG_MISC_CTRL, misc); wr(REG_MODE_CTRL, 8'h13);
    // start right after a tick so no bit of the closing is missed
    wait_tick();
    @(posedge I_MCLK);
    I_TX_UNDERRUN <= 1'b1;
    @(posedge I_MCLK);
    I_TX_UNDERRUN <= 1'b0;
    #1 chk({7'h00, O_UNDERRUN_EVT}, 8'h01);
    for (int i = 0; i < 16; i++) begin
      wait_tick();
      if (abort) chk({7'h00, O_TXD}, {7'h00, ABORT_FLAG[i]});
      else chk({7'h00, O_TXD}, {7'h00, I_TX_CRC});
      chk({7'h00, O_TXEMPTY_EVT}, {7'h00, i == 15});
    end
    if (mark) begin
      repeat (3) begin
        wait_tick();
        chk({7'h00, O_TXD}, 8'h01);
      end
    end
    wr(REG_MODE_CTRL, 8'h00); wr(REG_MISC_CTRL, 8'h00);
  endtask : t_close
  // eight bit times of idle line hold one whole flag (six ones) or all ones
  task automatic t_idle();
    logic [7:0] b;
    for (int mk = 0; mk < 2; mk++) begin
      wr(REG_MODE_CTRL, 8'h03); wr(REG_MISC_CTRL, {4'h0, mk[0], 3'h0}); settle();
      for (int i = 0; i < 8; i++) begin
        wait_tick();
        b[i] = O_TXD;
      end
      chk(8'($countones(b)), mk ? 8'h08 : 8'h06);
    end
    wr(REG_MODE_CTRL, 8'h00); wr(REG_MISC_CTRL, 8'h00);
  endtask : t_idle
  task automatic send_eop();
    @(posedge I_MCLK);
    send <= 1'b1;
    @(posedge I_MCLK);
    send <= 1'b0;
    repeat (12) wait_tick();
  endtask : send_eop
  task automatic t_loop();
    logic [7:0] q;
    wr(REG_MODE_CTRL, 8'h07); wr(REG_MISC_CTRL, 8'h02); wr(REG_MODE_CTRL, 8'h37);
    rd(REG_STATUS, q); chk(q & 8'h14, 8'h10);
    chk({7'h00, O_RX_BIT}, 8'h00);
    send_eop();
    rd(REG_STATUS, q); chk(q & 8'h04, 8'h04);
    chk({7'h00, O_RX_BIT}, 8'h01);
    wr(REG_MISC_CTRL, 8'h00);
    rd(REG_STATUS, q); chk(q & 8'h04, 8'h04);
    send_eop();
    rd(REG_STATUS, q); chk(q & 8'h04, 8'h00);
    wr(REG_MODE_CTRL, 8'h00); wr(REG_MISC_CTRL, 8'h02);
    rd(REG_STATUS, q); chk(q & 8'h10, 8'h00);
    wr(REG_MODE_CTRL, 8'h01); settle();
    chk({7'h00, O_TXD}, 8'h01);
    wr(REG_MODE_CTRL, 8'h09); settle();
    chk({7'h00, O_TXD}, 8'h00);
    wr(REG_MODE_CTRL, 8'h00); wr(REG_MISC_CTRL, 8'h00);
  endtask : t_loop
  // the end-of-poll burst carries a zero then ones, so the pattern matches that tail
  task automatic t_syncloop(input logic [7:0] misc, input logic [7:0] pat);
    logic [7:0] q;
    wr(REG_MODE_CTRL, 8'h09); wr(REG_MISC_CTRL, misc); wr(REG_SYNC_PAT, pat); wr(REG_SYNC_PAT, pat);
    wr(REG_MODE_CTRL, 8'h39); settle();
    chk({6'h00, O_TX_ENABLED, O_TXD}, 8'h00);
    send_eop();
    repeat (10) wait_tick();
    chk({7'h00, O_TX_ENABLED}, 8'h01);
    rd(REG_MODE_CTRL, q); chk(q, 8'h31);
    rd(REG_STATUS, q); chk(q & 8'h08, 8'h08);
    @(posedge I_MCLK);
    I_TX_DATA <= 1'b1;
    settle();
    chk({7'h00, O_TXD}, 8'h01);
    @(posedge I_MCLK);
    I_TX_DATA <= 1'b0;
    wr(REG_MODE_CTRL, 8'h00); wr(REG_MISC_CTRL, 8'h00);
  endtask : t_syncloop
  initial begin
    repeat (4) @(posedge I_MCLK);
    I_RST <= 1'b0;
    t_reset();
    t_sync();
    t_close(8'h00, 1'b0, 1'b0);
    t_close(8'h04, 1'b1, 1'b0);
    t_close(8'h0C, 1'b1, 1'b1);
    t_close(8'h06, 1'b0, 1'b0);
    t_idle();
    t_loop();
    t_syncloop(8'h02, 8'h7F);
    t_syncloop(8'h03, 8'h1F);
    wrap_up();
  end
endmodule : sdlc_sync_tx_misc_control_tb_top
